// file: verilog/insn_pkg.sv
// package for the 14-bit instruction format decoder
// assumes a single 100 MHz core clock shared by all design files
package insn_pkg;
    localparam int unsigned WORD_W       = 14;
    localparam int unsigned FILE_W       = 7;
    localparam int unsigned BIT_W        = 3;
    localparam int unsigned LIT_W        = 8;
    localparam int unsigned TARGET_W     = 11;
    localparam int unsigned OP_W         = 6;
    // field positions
    localparam int unsigned CLASS_HI     = 13;
    localparam int unsigned CLASS_LO     = 12;
    localparam int unsigned BYTE_OP_LO   = 8;
    localparam int unsigned DEST_POS     = 7;
    localparam int unsigned BITIDX_HI    = 9;
    localparam int unsigned BITIDX_LO    = 7;
    localparam int unsigned BIT_OP_LO    = 10;
    localparam int unsigned JUMP_OP_LO   = 11;
    localparam int unsigned JUMP_SEL_POS = 11;
    // file address range
    localparam logic [6:0]  FILE_MIN     = 7'h00;
    localparam logic [6:0]  FILE_MAX     = 7'h7f;
    // class codes in the top two bits
    localparam logic [1:0]  CLS_BYTE     = 2'h0;
    localparam logic [1:0]  CLS_BIT      = 2'h1;
    localparam logic [1:0]  CLS_JUMP     = 2'h2;
    localparam logic [1:0]  CLS_LIT      = 2'h3;
    // sub-opcodes of interest inside classes
    localparam logic [3:0]  BIT_TEST_CLR = 4'h6;
    localparam logic [3:0]  BIT_TEST_SET = 4'h7;
    localparam logic [5:0]  BYTE_DECSZ   = 6'h0b;
    localparam logic [5:0]  BYTE_INCSZ   = 6'h0f;
    localparam logic [5:0]  LIT_RETLIT   = 6'h34;
    localparam logic [13:0] INSN_RETURN  = 14'h0008;
    localparam logic [13:0] INSN_RETINT  = 14'h0009;
    localparam logic [13:0] INSN_NOP     = 14'h0000;
    // cycle accounting
    localparam int unsigned OSC_PER_CYCLE = 4;
    localparam int unsigned PHASE_W       = 2;
    localparam logic [1:0]  PHASE_LAST    = 2'h3;
    localparam logic [1:0]  PHASE_RESET   = 2'h0;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;

    typedef enum logic [1:0] {
        FMT_BYTE,
        FMT_BIT,
        FMT_LIT,
        FMT_JUMP
    } fmt_t;
endpackage : insn_pkg

// file: verilog/phase_counter.sv
// four-phase oscillator divider giving one instruction cycle per four clocks
// assumes the core clock is the oscillator clock
module phase_counter
    import insn_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst_n,
    output logic [PHASE_W-1:0]      phase,
    output logic                    cycle_end
);
    // free running phase count, wraps after the fourth period
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PHASE_RESET;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    assign cycle_end = (phase == PHASE_LAST);
endmodule : phase_counter

// file: verilog/field_splitter.sv
// combinational splitter of a 14-bit word into its operand fields
// assumes the word is stable for the whole decode
module field_splitter
    import insn_pkg::*;
(
    input  wire logic [WORD_W-1:0]   word,
    output fmt_t                     fmt,
    output logic [OP_W-1:0]          opcode,
    output logic [FILE_W-1:0]        file_addr,
    output logic                     dest_file,
    output logic [BIT_W-1:0]         bit_index,
    output logic [LIT_W-1:0]         literal,
    output logic [TARGET_W-1:0]      target
);
    // class from the top two bits, then the opcode within the class
    always_comb begin
        fmt       = FMT_BYTE;
        opcode    = word[CLASS_HI:BYTE_OP_LO];
        file_addr = word[FILE_W-1:0];
        dest_file = 1'b0;
        bit_index = '0;
        literal   = '0;
        target    = '0;
        case (word[CLASS_HI:CLASS_LO])
            CLS_BYTE: begin
                fmt       = FMT_BYTE;
                opcode    = word[CLASS_HI:BYTE_OP_LO];
                dest_file = word[DEST_POS];
            end
            CLS_BIT: begin
                fmt       = FMT_BIT;
                opcode    = {2'h0, word[CLASS_HI:BIT_OP_LO]};
                bit_index = word[BITIDX_HI:BITIDX_LO];
            end
            CLS_JUMP: begin
                fmt       = FMT_JUMP;
                opcode    = {3'h0, word[CLASS_HI:JUMP_OP_LO]};
                target    = word[TARGET_W-1:0];
                file_addr = '0;
            end
            CLS_LIT: begin
                fmt       = FMT_LIT;
                opcode    = word[CLASS_HI:BYTE_OP_LO];
                literal   = word[LIT_W-1:0];
                file_addr = '0;
            end
            default: begin
                fmt = FMT_BYTE;
            end
        endcase
    end
endmodule : field_splitter

// file: verilog/insn_format_decoder.sv
// top of the instruction format decoder: registers fields and paces cycles
// assumes the fetch logic holds insn_word valid for a cycle
module insn_format_decoder
    import insn_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire logic [insn_pkg::WORD_W-1:0] insn_word,
    input  wire logic                    cond_true,
    output insn_pkg::fmt_t               fmt,
    output logic [insn_pkg::OP_W-1:0]     opcode,
    output logic [insn_pkg::FILE_W-1:0]   file_addr,
    output logic                         dest_to_acc,
    output logic                         dest_to_file,
    output logic [insn_pkg::BIT_W-1:0]    bit_index,
    output logic [insn_pkg::LIT_W-1:0]    literal,
    output logic [insn_pkg::TARGET_W-1:0] target,
    output logic                         changes_pc,
    output logic                         is_cond_test,
    output logic                         nop_cycle,
    output logic                         fetch_next,
    output logic                         cycle_start
);
    import insn_pkg::*;

    // low byte of the program counter as it appears in the register file
    localparam logic [FILE_W-1:0] PC_LOW_ADDR = 7'h02;

    logic [PHASE_W-1:0]  phase;
    logic                cycle_end;
    fmt_t                split_fmt;
    logic [OP_W-1:0]     split_op;
    logic [FILE_W-1:0]   split_file;
    logic                split_dest;
    logic [BIT_W-1:0]    split_bit;
    logic [LIT_W-1:0]    split_lit;
    logic [TARGET_W-1:0] split_target;
    logic                word_pc_change;
    logic                word_cond;
    logic                flush_pending;
    logic                next_flush;

    // four-phase divider that marks the last oscillator period of a cycle
    phase_counter u_phase (
        .clock     (clock),
        .rst_n     (rst_n),
        .phase     (phase),
        .cycle_end (cycle_end)
    );

    // operand fields of the word now offered, split by class
    field_splitter u_split (
        .word      (insn_word),
        .fmt       (split_fmt),
        .opcode    (split_op),
        .file_addr (split_file),
        .dest_file (split_dest),
        .bit_index (split_bit),
        .literal   (split_lit),
        .target    (split_target)
    );

    // true when the word writes the program counter; the two low opcode bits
    // of the literal return are don't-care, so they stay out of the match,
    // and a byte op that stores into the program counter low byte counts too
    function automatic logic pc_writer(input logic [WORD_W-1:0] w);
        logic r;
        r = 1'b0;
        if (w[CLASS_HI:CLASS_LO] == CLS_JUMP) begin
            r = 1'b1;
        end else if (w[CLASS_HI:BYTE_OP_LO+2] == LIT_RETLIT[5:2]) begin
            r = 1'b1;
        end else if (w == INSN_RETURN || w == INSN_RETINT) begin
            r = 1'b1;
        end else if (w[CLASS_HI:CLASS_LO] == CLS_BYTE && w[DEST_POS]
                     && w[FILE_W-1:0] == PC_LOW_ADDR) begin
            r = 1'b1;  // direct write to the program counter low byte
        end
        return r;
    endfunction : pc_writer

    // true when the word is a skip-on-condition test; whether the skip is
    // taken depends on cond_true, which the datapath settles in the same
    // cycle
    function automatic logic cond_tester(input logic [WORD_W-1:0] w);
        logic r;
        r = 1'b0;
        case (w[CLASS_HI:CLASS_LO])
            CLS_BYTE: begin
                r = (w[CLASS_HI:BYTE_OP_LO] == BYTE_DECSZ)
                  || (w[CLASS_HI:BYTE_OP_LO] == BYTE_INCSZ);
            end
            CLS_BIT: begin
                r = (w[CLASS_HI:BIT_OP_LO] == BIT_TEST_CLR)
                  || (w[CLASS_HI:BIT_OP_LO] == BIT_TEST_SET);
            end
            default: begin
                r = 1'b0;
            end
        endcase
        return r;
    endfunction : cond_tester

    // decode of the word now offered; only looked at on a cycle end
    assign word_pc_change = pc_writer(insn_word);
    assign word_cond      = cond_tester(insn_word);

    // field registers load at the end of each executed cycle; in a dead
    // cycle they all fall to zero so that the core sees a plain no-op word
    // and no stale operand of the word that caused the dead cycle

    // format class of the executed word
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fmt <= FMT_BYTE;
        end else if (cycle_end) begin
            if (flush_pending) begin
                fmt <= FMT_BYTE;
            end else begin
                fmt <= split_fmt;
            end
        end
    end

    // opcode within the class; the dead cycle carries the no-op opcode
    // so that nothing downstream repeats the branch
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            opcode <= '0;
        end else if (cycle_end) begin
            if (flush_pending) begin
                opcode <= INSN_NOP[CLASS_HI:BYTE_OP_LO];
            end else begin
                opcode <= split_op;
            end
        end
    end

    // register address, masked to the data space of the file operand;
    // the splitter already zeroes it for classes without a file operand
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            file_addr <= FILE_MIN;
        end else if (cycle_end) begin
            if (flush_pending) begin
                file_addr <= FILE_MIN;
            end else begin
                file_addr <= split_file & FILE_MAX;
            end
        end
    end

    // destination select, only meaningful for the byte class; the two
    // flags are never high together
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dest_to_acc  <= 1'b0;
            dest_to_file <= 1'b0;
        end else if (cycle_end) begin
            if (flush_pending) begin
                dest_to_acc  <= 1'b0;
                dest_to_file <= 1'b0;
            end else begin
                dest_to_acc  <= (split_fmt == FMT_BYTE) && !split_dest;
                dest_to_file <= (split_fmt == FMT_BYTE) && split_dest;
            end
        end
    end

    // bit index of the bit class
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bit_index <= '0;
        end else if (cycle_end) begin
            if (flush_pending) begin
                bit_index <= '0;
            end else begin
                bit_index <= split_bit;
            end
        end
    end

    // immediate byte of the literal class
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            literal <= '0;
        end else if (cycle_end) begin
            if (flush_pending) begin
                literal <= '0;
            end else begin
                literal <= split_lit;
            end
        end
    end

    // branch target of call and jump
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            target <= '0;
        end else if (cycle_end) begin
            if (flush_pending) begin
                target <= '0;
            end else begin
                target <= split_target;
            end
        end
    end

    // program counter write flag; cleared in the dead cycle so that a
    // branch is never reported twice
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            changes_pc <= 1'b0;
        end else if (cycle_end) begin
            if (flush_pending) begin
                changes_pc <= 1'b0;
            end else begin
                changes_pc <= word_pc_change;
            end
        end
    end

    // conditional test flag of the executed word
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            is_cond_test <= 1'b0;
        end else if (cycle_end) begin
            if (flush_pending) begin
                is_cond_test <= 1'b0;
            end else begin
                is_cond_test <= word_cond;
            end
        end
    end

    // dead-cycle request for the word now offered: a program counter write,
    // or a skip test whose condition the datapath reports as true
    always_comb begin
        next_flush = 1'b0;
        if (word_pc_change) begin
            next_flush = 1'b1;
        end else if (word_cond && cond_true) begin
            next_flush = 1'b1;
        end
    end

    // a taken branch or true test inserts one dead cycle; the dead cycle
    // itself never asks for another, so two dead cycles cannot chain
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flush_pending <= 1'b0;
        end else if (cycle_end) begin
            if (flush_pending) begin
                flush_pending <= 1'b0;
            end else begin
                flush_pending <= next_flush;
            end
        end
    end

    // cycle start marks the first oscillator period of every cycle; it
    // rises together with the fetch pulse, and also rises in a dead cycle, where no fetch pulse comes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cycle_start <= 1'b0;
        end else begin
            cycle_start <= cycle_end;
        end
    end

    // no-op marker stands over the whole dead cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nop_cycle <= 1'b0;
        end else if (cycle_end) begin
            nop_cycle <= flush_pending;
        end
    end

    // fetch pulse lasts one clock and is withheld in a dead cycle, so the
    // fetch logic never loses a word while the core idles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fetch_next <= 1'b0;
        end else if (cycle_end) begin
            fetch_next <= !flush_pending;
        end else begin
            fetch_next <= 1'b0;
        end
    end
endmodule : insn_format_decoder

// file: sim/insn_format_decoder_asserts.sv
// checker of cycle pacing and field extraction at the decoder ports
// assumes one clock domain and binding to insn_format_decoder
module insn_format_decoder_asserts
    import insn_pkg::*;
(
    input wire logic                clock,
    input wire logic                rst_n,
    input wire logic [WORD_W-1:0]   insn_word,
    input wire logic                cond_true,
    input wire fmt_t                fmt,
    input wire logic [FILE_W-1:0]   file_addr,
    input wire logic                dest_to_acc,
    input wire logic                dest_to_file,
    input wire logic [BIT_W-1:0]    bit_index,
    input wire logic [LIT_W-1:0]    literal,
    input wire logic [TARGET_W-1:0] target,
    input wire logic                changes_pc,
    input wire logic                is_cond_test,
    input wire logic                nop_cycle,
    input wire logic                fetch_next,
    input wire logic                cycle_start
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // pacing: fetches at least four clocks apart, cycle starts exactly four apart
    a_fetch_spacing: assert property (
        fetch_next |=> !fetch_next [*3]) else $error("fetch pulses too close");
    a_cycle_period: assert property (
        cycle_start |=> !cycle_start [*3] ##1 cycle_start) else $error("cycle period not four");
    a_start_after_fetch: assert property (
        fetch_next |-> cycle_start) else $error("cycle start missing at fetch");
    // flow: plain words one cycle, branches and true tests add a no-op
    a_plain_one_cycle: assert property (
        fetch_next && !changes_pc && !(is_cond_test && $past(cond_true)) |-> ##4 fetch_next)
        else $error("plain word not one cycle");
    a_nop_follows: assert property (
        fetch_next && (changes_pc || (is_cond_test && $past(cond_true)))
        |-> ##4 (nop_cycle && !fetch_next) ##4 (fetch_next && !nop_cycle))
        else $error("no-op cycle missing");
    a_nop_fields_zero: assert property (
        nop_cycle |-> fmt == FMT_BYTE && target == '0 && literal == '0 && !fetch_next)
        else $error("no-op cycle shows fields");
    // fields follow the word taken at the fetch edge
    a_class_map: assert property (
        fetch_next |-> fmt == fmt_t'({$past(insn_word[13]), ^$past(insn_word[13:12])}))
        else $error("class from top bits wrong");
    a_file_dest: assert property (
        fetch_next && fmt == FMT_BYTE |-> file_addr == $past(insn_word[6:0])
        && dest_to_file == $past(insn_word[7]) && dest_to_acc != dest_to_file)
        else $error("byte fields wrong");
    a_bit_index: assert property (
        fetch_next && fmt == FMT_BIT |-> bit_index == $past(insn_word[9:7]))
        else $error("bit index wrong");
    a_jump_target: assert property (
        fetch_next && fmt == FMT_JUMP |-> target == $past(insn_word[10:0]))
        else $error("jump target wrong");
endmodule : insn_format_decoder_asserts

bind insn_format_decoder insn_format_decoder_asserts i_insn_format_decoder_asserts (
    .clock, .rst_n, .insn_word, .cond_true, .fmt, .file_addr, .dest_to_acc, .dest_to_file,
    .bit_index, .literal, .target, .changes_pc, .is_cond_test, .nop_cycle, .fetch_next,
    .cycle_start);

// file: sim/insn_format_decoder_tb_top.sv
// self-checking bench for the instruction format decoder
// assumes the package, the design and the checker are compiled first
module insn_format_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import insn_pkg::*;
    logic                clock = 1'b0;
    logic                rst_n = 1'b0;
    logic [WORD_W-1:0]   insn_word = 14'h0000;
    logic                cond_true = 1'b0;
    fmt_t                fmt;
    logic [OP_W-1:0]     opcode;
    logic [FILE_W-1:0]   file_addr;
    logic [BIT_W-1:0]    bit_index;
    logic [LIT_W-1:0]    literal;
    logic [TARGET_W-1:0] target;
    logic                dest_to_acc, dest_to_file, changes_pc, is_cond_test;
    logic                nop_cycle, fetch_next, cycle_start;
    int                  mismatches = 0;
    int                  check_count = 0;
    int                  prev_gap = 4;

    insn_format_decoder i_insn_format_decoder (.clock, .rst_n, .insn_word, .cond_true, .fmt,
        .opcode, .file_addr, .dest_to_acc, .dest_to_file, .bit_index, .literal, .target,
        .changes_pc, .is_cond_test, .nop_cycle, .fetch_next, .cycle_start);

    // clock at 100 MHz
    initial begin
        forever #5 clock = ~clock;
    end

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_val

    // present a word, wait for its fetch, then judge fields and spacing
    task automatic issue(input logic [13:0] w, input logic c, input logic pc, input logic tst);
        int         n;
        logic       saw_nop;
        logic [1:0] cls;
        n = 0;
        saw_nop = 1'b0;
        cls = w[13:12];
        insn_word = w;
        cond_true = c;
        do begin
            @(negedge clock);
            n++;
            saw_nop |= nop_cycle;
        end while (fetch_next !== 1'b1 && n < 12);
        if (prev_gap != 0) begin
            check_val(16'(n), 16'(prev_gap), "spacing");
            check_val(16'(saw_nop), 16'(prev_gap == 8), "no-op");
        end
        check_val(16'(fmt), 16'(cls[1] ? (cls[0] ? FMT_LIT : FMT_JUMP) : fmt_t'(cls)), "class");
        check_val(16'(file_addr), 16'(cls[1] ? 7'h00 : w[6:0]), "file");
        check_val(16'({dest_to_acc, dest_to_file}), 16'(cls == 2'h0 ? {!w[7], w[7]} : 2'h0),
            "dest");
        check_val(16'(bit_index), 16'(cls == 2'h1 ? w[9:7] : 3'h0), "bit");
        check_val(16'(literal), 16'(cls == 2'h3 ? w[7:0] : 8'h00), "literal");
        check_val(16'(target), 16'(cls == 2'h2 ? w[10:0] : 11'h000), "target");
        check_val(16'(opcode), 16'(cls == 2'h1 ? {2'h0, w[13:10]} : cls == 2'h2 ?
            {3'h0, w[13:11]} : w[13:8]), "opcode");
        check_val(16'({changes_pc, is_cond_test}), 16'({pc, tst}), "flags");
        check_val(16'({fetch_next, cycle_start}), 16'h0003, "pacing");
        prev_gap = (pc || (tst && c)) ? 8 : 4;
    endtask : issue

    // byte ops at both address ends, both destinations, skip ops both ways
    task automatic s_byte();
        for (int i = 0; i < 4; i++) begin
            issue({6'h07, i[0], {7{i[1]}}}, 1'b1, 1'b0, 1'b0);
            issue({i[1] ? BYTE_INCSZ : BYTE_DECSZ, 8'h25}, i[0], 1'b0, 1'b1);
        end
    endtask : s_byte

    // every bit op with every bit index, tests true and false
    task automatic s_bit();
        for (int i = 0; i < 32; i++) begin
            issue({2'h1, i[4:3], i[2:0], 7'h55}, i[0], 1'b0, i[4]);
        end
    endtask : s_bit

    // whole literal class including don't-care variants
    task automatic s_lit();
        for (int j = 0; j < 16; j++) begin
            issue({6'h30 + 6'(j), 8'(j * 17)}, 1'b1, 6'(j) >> 2 == 6'h1, 1'b0);
        end
    endtask : s_lit

    // call and jump at target ends, returns, then plain words
    task automatic s_jump();
        for (int i = 0; i < 4; i++) begin
            issue({2'h2, i[0], {11{i[1]}}}, 1'b0, 1'b1, 1'b0);
        end
        issue(INSN_RETURN, 1'b0, 1'b1, 1'b0);
        issue(INSN_RETINT, 1'b1, 1'b1, 1'b0);
        issue(INSN_NOP, 1'b1, 1'b0, 1'b0);
        issue(INSN_NOP, 1'b0, 1'b0, 1'b0);
    endtask : s_jump

    // reset in mid-run with a dead cycle pending: outputs clear, fetch resumes
    task automatic s_reset();
        issue({2'h2, 1'b1, 11'h2aa}, 1'b0, 1'b1, 1'b0);
        rst_n = 1'b0;
        @(negedge clock);
        check_val(16'({fmt, opcode, file_addr, dest_to_acc}), 16'h0, "rst fields");
        check_val(16'({dest_to_file, bit_index, literal}), 16'h0, "rst operands");
        check_val(16'(target), 16'h0, "rst target");
        check_val(16'({changes_pc, is_cond_test}), 16'h0, "rst flags");
        check_val(16'({nop_cycle, fetch_next, cycle_start}), 16'h0, "rst pacing");
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        prev_gap = 4;
        issue(INSN_RETURN, 1'b0, 1'b1, 1'b0);
        issue({6'h08, 8'h80}, 1'b0, 1'b0, 1'b0);
    endtask : s_reset

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // watchdog
    initial begin
        #50000;
        mismatches++;
        end_of_test();
    end

    // main sequence
    initial begin
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        s_byte();
        s_bit();
        s_lit();
        s_jump();
        s_reset();
        end_of_test();
    end
endmodule : insn_format_decoder_tb_top
